// ==== hdl/icm_defs.vh ====
// Purpose: Offsets, bit positions and timing counts of the iso mask and
//          event block.
// Assumes: 10 MHz core clock.
// Notes:   Definitions only.
`ifndef ICM_DEFS_VH
`define ICM_DEFS_VH

`define ICM_OFS_CHAN_HIGH_SET   8'h70
`define ICM_OFS_CHAN_HIGH_CLR   8'h74
`define ICM_OFS_CHAN_LOW_SET    8'h78
`define ICM_OFS_CHAN_LOW_CLR    8'h7C
`define ICM_OFS_EVENT_SET       8'h80
`define ICM_OFS_EVENT_CLR       8'h84

`define ICM_BIT_TIME_MISMATCH   23
`define ICM_BIT_FATAL_HALT      24
`define ICM_BIT_PERIOD_OVERRUN  25
`define ICM_BIT_XCVR_REG        26
`define ICM_CTX_COUNT           4

// Event bits this block can hold; others read as zero
`define ICM_EVENT_IMPL          32'h4780_000F
`define ICM_MASK_RESET          32'h0000_0000
`define ICM_EVENT_RESET         32'h0000_0000

`define ICM_CLK_PERIOD_NS       100
`define ICM_PERIOD_LIMIT_NS     125000
// 125 us at 100 ns a cycle, sized to the period counter
`define ICM_PERIOD_LIMIT_CYC    11'h04E2
`define ICM_TIMER_W             11

`endif

// ==== hdl/icm_event_latch.v ====
// Purpose: Edge-latched event bank with software set and clear.
// Assumes: Sources are levels from logic on the same clock.
// Notes:   A set in the same cycle as a clear wins.
`timescale 1ns/1ps
`include "icm_defs.vh"

module icm_event_latch (
    clk,
    reset,
    srcLevel,
    srcBlock,
    swSet,
    swClear,
    events_r
);
    input  wire        clk;
    input  wire        reset;
    input  wire [31:0] srcLevel;
    input  wire [31:0] srcBlock;
    input  wire [31:0] swSet;
    input  wire [31:0] swClear;
    output reg  [31:0] events_r;

    reg  [31:0] srcPrev_r;
    wire [31:0] rise;
    wire [31:0] events_nxt;

    // Edge, not level, so a stuck source cannot re-set after a clear
    assign rise = srcLevel & ~srcPrev_r;
    assign events_nxt = ((events_r & ~swClear)
                        | (rise & ~srcBlock) | swSet)
                        & `ICM_EVENT_IMPL;

    always @(posedge clk) begin
        if (reset) begin
            srcPrev_r <= 32'h0000_0000;
            events_r  <= `ICM_EVENT_RESET;
        end else begin
            srcPrev_r <= srcLevel;
            events_r  <= events_nxt;
        end
    end
endmodule

// ==== hdl/icm_irq_regs.v ====
// Purpose: Iso receive channel masks and latched interrupt events.
// Assumes: Single 10 MHz clock, synchronous reset, one-cycle register
//          strobes; all event sources are on the same clock.
// Notes:   Read data appear one cycle after the read strobe.
// Behaviour
// - Channels 32..63 accepted only while matching upper mask bit is one.
// - Channels 0..31 accepted only while matching lower mask bit is one.
// - Lower mask: set alias 78h, clear alias 7Ch, same bits.
// - Event bits latch on a source's rising edge, not its level.
// - Writing one to event set alias 80h sets that event bit.
// - Event bits clear only by writing one to clear alias 84h.
// - Reading clear alias returns events ANDed with the event mask.
// - Bit 26 sets when a transceiver register byte has arrived.
// - Timing root: over 125 us start-to-gap sets bit 25, drops root.
// - Bit 24 sets when any error halts a subunit.
// - While bit 24 set, halted contexts' normal events are blocked.
// - Bit 23 sets when received cycle time differs from local time.
// - Reading either upper mask alias returns the upper mask.
// - Upper mask: set alias 70h, clear alias 74h.
`timescale 1ns/1ps
`include "icm_defs.vh"

module icm_irq_regs (
    clk,
    reset,
    regAddr,
    regWrite,
    regRead,
    regWdata,
    regRdata_r,
    regReadValid_r,
    irqEventEnables,
    isoRxValid,
    isoRxChannel,
    isoRxAccept_r,
    transceiverRegArrived,
    timingRootSet,
    cycleStartSent,
    subactionGapEnd,
    timingRootSelect_r,
    ctxHalt,
    ctxEvent,
    cycleStartRcvd,
    rxCycleSeconds,
    rxCycleCount,
    busTimeSeconds,
    busTimeCount,
    latchedIrqEvents_r,
    upperRxChanEnables_r,
    lowerRxChanEnables_r
);
    input  wire        clk;
    input  wire        reset;
    input  wire [7:0]  regAddr;
    input  wire        regWrite;
    input  wire        regRead;
    input  wire [31:0] regWdata;
    output reg  [31:0] regRdata_r;
    output reg         regReadValid_r;
    input  wire [31:0] irqEventEnables;
    input  wire        isoRxValid;
    input  wire [5:0]  isoRxChannel;
    output reg         isoRxAccept_r;
    input  wire        transceiverRegArrived;
    input  wire        timingRootSet;
    input  wire        cycleStartSent;
    input  wire        subactionGapEnd;
    output reg         timingRootSelect_r;
    input  wire [3:0]  ctxHalt;
    input  wire [3:0]  ctxEvent;
    input  wire        cycleStartRcvd;
    input  wire [6:0]  rxCycleSeconds;
    input  wire [12:0] rxCycleCount;
    input  wire [6:0]  busTimeSeconds;
    input  wire [12:0] busTimeCount;
    output wire [31:0] latchedIrqEvents_r;
    output reg  [31:0] upperRxChanEnables_r;
    output reg  [31:0] lowerRxChanEnables_r;

    localparam [`ICM_TIMER_W-1:0] LIMIT_CYC =
        `ICM_PERIOD_LIMIT_CYC;

    function [31:0] set_clear;
        input [31:0] cur;
        input [31:0] setBits;
        input [31:0] clrBits;
        begin
            set_clear = (cur & ~clrBits) | setBits;
        end
    endfunction

    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    wire [31:0] wrHighSet;
    wire [31:0] wrHighClr;
    wire [31:0] wrLowSet;
    wire [31:0] wrLowClr;
    wire [31:0] wrEvtSet;
    wire [31:0] wrEvtClr;
    wire [31:0] evtSrc;
    wire [31:0] evtBlock;
    reg  [31:0] readMux;
    reg  [3:0]  haltCause_r;
    reg  [3:0]  haltCause_nxt;
    reg  [`ICM_TIMER_W-1:0] periodCnt_r;
    reg         periodRun_r;
    reg         overrun_r;
    reg         mismatch_r;
    wire        overrunNow;

    assign wrHighSet = (regWrite & hit(regAddr, `ICM_OFS_CHAN_HIGH_SET))
                       ? regWdata : 32'h0000_0000;
    assign wrHighClr = (regWrite & hit(regAddr, `ICM_OFS_CHAN_HIGH_CLR))
                       ? regWdata : 32'h0000_0000;
    assign wrLowSet  = (regWrite & hit(regAddr, `ICM_OFS_CHAN_LOW_SET))
                       ? regWdata : 32'h0000_0000;
    assign wrLowClr  = (regWrite & hit(regAddr, `ICM_OFS_CHAN_LOW_CLR))
                       ? regWdata : 32'h0000_0000;
    assign wrEvtSet  = (regWrite & hit(regAddr, `ICM_OFS_EVENT_SET))
                       ? regWdata : 32'h0000_0000;
    assign wrEvtClr  = (regWrite & hit(regAddr, `ICM_OFS_EVENT_CLR))
                       ? regWdata : 32'h0000_0000;

    // Channel masks
    always @(posedge clk) begin
        if (reset) begin
            upperRxChanEnables_r <= `ICM_MASK_RESET;
            lowerRxChanEnables_r <= `ICM_MASK_RESET;
        end else begin
            upperRxChanEnables_r <= set_clear(upperRxChanEnables_r,
                                              wrHighSet, wrHighClr);
            lowerRxChanEnables_r <= set_clear(lowerRxChanEnables_r,
                                              wrLowSet, wrLowClr);
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            isoRxAccept_r <= 1'b0;
        end else if (isoRxChannel[5]) begin
            isoRxAccept_r <= isoRxValid
                & upperRxChanEnables_r[isoRxChannel[4:0]];
        end else begin
            isoRxAccept_r <= isoRxValid
                & lowerRxChanEnables_r[isoRxChannel[4:0]];
        end
    end

    // Cycle period watchdog while timing root
    assign overrunNow = periodRun_r & ~subactionGapEnd
                        & (periodCnt_r == LIMIT_CYC);

    always @(posedge clk) begin
        if (reset) begin
            periodRun_r        <= 1'b0;
            periodCnt_r        <= {`ICM_TIMER_W{1'b0}};
            overrun_r          <= 1'b0;
            timingRootSelect_r <= 1'b0;
        end else begin
            overrun_r <= overrunNow;
            if (overrunNow) begin
                timingRootSelect_r <= 1'b0;
            end else if (timingRootSet) begin
                timingRootSelect_r <= 1'b1;
            end
            if (overrunNow | subactionGapEnd) begin
                periodRun_r <= 1'b0;
            end else if (cycleStartSent & timingRootSelect_r) begin
                periodRun_r <= 1'b1;
                periodCnt_r <= {`ICM_TIMER_W{1'b0}};
            end else if (periodRun_r) begin
                periodCnt_r <= periodCnt_r + 1'b1;
            end
        end
    end

    // Received cycle time check
    always @(posedge clk) begin
        if (reset) begin
            mismatch_r <= 1'b0;
        end else begin
            mismatch_r <= cycleStartRcvd
                & ((rxCycleSeconds != busTimeSeconds)
                   | (rxCycleCount != busTimeCount));
        end
    end

    // Contexts that halted stay blocked until the halt event is cleared and no context is halting
    always @* begin
        haltCause_nxt = haltCause_r | ctxHalt;
        if (!latchedIrqEvents_r[`ICM_BIT_FATAL_HALT] && ctxHalt == 4'h0) begin
            haltCause_nxt = 4'h0;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            haltCause_r <= 4'h0;
        end else begin
            haltCause_r <= haltCause_nxt;
        end
    end

    assign evtBlock = {28'h000_0000, haltCause_nxt};
    assign evtSrc = {5'h00,
                     transceiverRegArrived,
                     overrun_r,
                     |ctxHalt,
                     mismatch_r,
                     19'h0_0000,
                     ctxEvent};

    icm_event_latch u_events (
        .clk      (clk),
        .reset    (reset),
        .srcLevel (evtSrc),
        .srcBlock (evtBlock),
        .swSet    (wrEvtSet),
        .swClear  (wrEvtClr),
        .events_r (latchedIrqEvents_r)
    );

    // Register read port
    always @* begin
        case (regAddr)
            `ICM_OFS_CHAN_HIGH_SET: readMux = upperRxChanEnables_r;
            `ICM_OFS_CHAN_HIGH_CLR: readMux = upperRxChanEnables_r;
            `ICM_OFS_CHAN_LOW_SET:  readMux = lowerRxChanEnables_r;
            `ICM_OFS_CHAN_LOW_CLR:  readMux = lowerRxChanEnables_r;
            `ICM_OFS_EVENT_SET:     readMux = latchedIrqEvents_r;
            `ICM_OFS_EVENT_CLR:
                readMux = latchedIrqEvents_r & irqEventEnables;
            default:                readMux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            regRdata_r     <= 32'h0000_0000;
            regReadValid_r <= 1'b0;
        end else begin
            regReadValid_r <= regRead;
            if (regRead) begin
                regRdata_r <= readMux;
            end
        end
    end
endmodule

// ==== bench/icm_irq_regs_assertions.sv ====
// Purpose: Assertions on the iso mask and event register block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees top-level ports only.
`timescale 1ns/1ps

module icm_irq_regs_chk (
    input wire        clk,
    input wire        reset,
    input wire [7:0]  regAddr,
    input wire        regWrite,
    input wire        regRead,
    input wire [31:0] regWdata,
    input wire [31:0] regRdata_r,
    input wire        regReadValid_r,
    input wire [31:0] irqEventEnables,
    input wire        isoRxValid,
    input wire [5:0]  isoRxChannel,
    input wire        isoRxAccept_r,
    input wire        transceiverRegArrived,
    input wire        timingRootSelect_r,
    input wire [31:0] latchedIrqEvents_r,
    input wire [31:0] upperRxChanEnables_r,
    input wire [31:0] lowerRxChanEnables_r
);
    wire [31:0] ev  = latchedIrqEvents_r;
    wire [31:0] wd  = regWdata;
    wire [31:0] lo  = lowerRxChanEnables_r;
    wire [31:0] up  = upperRxChanEnables_r;
    wire [63:0] chm = {up, lo};
    wire [31:0] imp = 32'h4780_000F;
    wire        wr  = regWrite;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    AST_RD_VALID: assert property (regRead |=> regReadValid_r)
        else $error("read gave no valid pulse");
    AST_LOW_SET: assert property (wr && regAddr == 8'h78 |=>
        (lo & $past(wd)) == $past(wd)) else $error("low set lost");
    AST_LOW_CLR: assert property (wr && regAddr == 8'h7C |=>
        (lo & $past(wd)) == 32'h0000_0000) else $error("low clear lost");
    AST_HI_SET: assert property (wr && regAddr == 8'h70 |=>
        (up & $past(wd)) == $past(wd)) else $error("high set lost");
    AST_EV_SET: assert property (wr && regAddr == 8'h80 |=>
        (ev & $past(wd)) == ($past(wd) & imp)) else $error("event set lost");
    AST_EV_HOLD: assert property (!(wr && regAddr == 8'h84) |=>
        (ev & $past(ev)) == $past(ev)) else $error("event bit dropped");
    AST_ACCEPT: assert property (isoRxValid |=>
        isoRxAccept_r == $past(chm[isoRxChannel])) else $error("accept");
    AST_XCVR: assert property ($rose(transceiverRegArrived) &&
        !$past(reset) |=> ev[26]) else $error("bit 26 not latched");
    AST_OVERRUN: assert property ($fell(timingRootSelect_r) &&
        !$past(reset) |=> ev[25]) else $error("bit 25 not set");
    AST_CLR_READ: assert property (regRead && regAddr == 8'h84 |=>
        regRdata_r == $past(ev & irqEventEnables)) else $error("84h read");

    COV_ACCEPT: cover property (isoRxAccept_r);
    COV_OVERRUN: cover property ($fell(timingRootSelect_r));
    COV_READ: cover property (regReadValid_r && regRdata_r != 32'h0000_0000);
endmodule

bind icm_irq_regs icm_irq_regs_chk chk (
    .clk                   (clk),
    .reset                 (reset),
    .regAddr               (regAddr),
    .regWrite              (regWrite),
    .regRead               (regRead),
    .regWdata              (regWdata),
    .regRdata_r            (regRdata_r),
    .regReadValid_r        (regReadValid_r),
    .irqEventEnables       (irqEventEnables),
    .isoRxValid            (isoRxValid),
    .isoRxChannel          (isoRxChannel),
    .isoRxAccept_r         (isoRxAccept_r),
    .transceiverRegArrived (transceiverRegArrived),
    .timingRootSelect_r    (timingRootSelect_r),
    .latchedIrqEvents_r    (latchedIrqEvents_r),
    .upperRxChanEnables_r  (upperRxChanEnables_r),
    .lowerRxChanEnables_r  (lowerRxChanEnables_r)
);

// ==== bench/icm_irq_regs_test.sv ====
// Purpose: Register-level test of the iso mask and event block.
// Assumes: 10 MHz clock, synchronous reset held 16 cycles.
// Notes:   Overrun case waits out the full 1250-cycle limit.
`timescale 1ns/1ps

module icm_irq_regs_test;
    reg         clk = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0;
    reg         isoRxValid = 1'h0, transceiverRegArrived = 1'h0;
    reg         timingRootSet = 1'h0, cycleStartSent = 1'h0;
    reg         subactionGapEnd = 1'h0, cycleStartRcvd = 1'h0;
    reg  [7:0]  regAddr = 8'h00;
    reg  [31:0] regWdata = 32'h0000_0000;
    reg  [31:0] irqEventEnables = 32'h0400_0001;
    reg  [5:0]  isoRxChannel = 6'h00;
    reg  [3:0]  ctxHalt = 4'h0, ctxEvent = 4'h0;
    reg  [6:0]  rxCycleSeconds = 7'h05, busTimeSeconds = 7'h05;
    reg  [12:0] rxCycleCount = 13'h0064, busTimeCount = 13'h0064;
    reg  [63:0] expM = {32'h8000_0002, 32'hA5A5_0000};
    wire [31:0] regRdata_r, latchedIrqEvents_r;
    wire [31:0] upperRxChanEnables_r, lowerRxChanEnables_r;
    wire        regReadValid_r, isoRxAccept_r, timingRootSelect_r;
    integer     error_cnt = 0, compares = 0, i;

    icm_irq_regs uut (.*);

    initial forever #50 clk = ~clk;

    task chk(input string n, input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %s expected %h seen %h", n, exp, got);
            end
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask

    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            regAddr <= a;
            regWdata <= d;
            regWrite <= 1'h1;
            @(posedge clk);
            regWrite <= 1'h0;
            #1;
        end
    endtask

    task rd(input [7:0] a, input [31:0] e);
        begin
            @(posedge clk);
            regAddr <= a;
            regRead <= 1'h1;
            @(posedge clk);
            regRead <= 1'h0;
            #1;
            chk("rvalid", {31'h0, regReadValid_r}, 32'h0000_0001);
            chk("rdata", regRdata_r, e);
        end
    endtask

    // Strobe stays high one cycle; bit 23 is due two edges after it
    task cst(input [6:0] s, input [12:0] c);
        begin
            @(posedge clk);
            rxCycleSeconds <= s;
            rxCycleCount <= c;
            cycleStartRcvd <= 1'h1;
            @(posedge clk);
            cycleStartRcvd <= 1'h0;
            cyc(2);
            #1;
        end
    endtask

    task complete_run;
        begin
            $display("errors %0d compares %0d", error_cnt, compares);
            if (error_cnt == 0 && compares > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    initial begin
        cyc(16);
        reset <= 1'h0;
        #1 chk("lo", lowerRxChanEnables_r, 32'h0000_0000);
        chk("ev", latchedIrqEvents_r, 32'h0000_0000);
        wr(8'h78, 32'hA5A5_0001);
        chk("lo", lowerRxChanEnables_r, 32'hA5A5_0001);
        wr(8'h7C, 32'h0000_0001);
        chk("lo", lowerRxChanEnables_r, 32'hA5A5_0000);
        rd(8'h78, 32'hA5A5_0000);
        rd(8'h7C, 32'hA5A5_0000);
        // Unmapped offset: write ignored, read gives zero
        wr(8'h6C, 32'hFFFF_FFFF);
        chk("lo", lowerRxChanEnables_r, 32'hA5A5_0000);
        rd(8'h6C, 32'h0000_0000);
        wr(8'h70, 32'h8000_0003);
        wr(8'h74, 32'h0000_0001);
        rd(8'h70, 32'h8000_0002);
        rd(8'h74, 32'h8000_0002);
        for (i = 0; i < 64; i = i + 1) begin
            @(posedge clk);
            isoRxValid <= 1'h1;
            isoRxChannel <= i[5:0];
            @(posedge clk);
            #1 chk("acc", {31'h0, isoRxAccept_r}, {31'h0, expM[i]});
        end
        @(posedge clk);
        isoRxValid <= 1'h0;
        // Reserved bits must stay zero despite an all-ones set
        wr(8'h80, 32'hFFFF_FFFF);
        chk("ev", latchedIrqEvents_r, 32'h4780_000F);
        rd(8'h84, 32'h0400_0001);
        rd(8'h80, 32'h4780_000F);
        wr(8'h80, 32'h0000_0000);
        chk("ev", latchedIrqEvents_r, 32'h4780_000F);
        wr(8'h84, 32'h0000_0003);
        chk("ev", latchedIrqEvents_r, 32'h4780_000C);
        wr(8'h84, 32'hFFFF_FFFF);
        @(posedge clk);
        transceiverRegArrived <= 1'h1;
        cyc(3);
        #1 chk("ev", latchedIrqEvents_r, 32'h0400_0000);
        wr(8'h84, 32'h0400_0000);
        cyc(4);
        #1 chk("ev", latchedIrqEvents_r, 32'h0000_0000);
        cst(7'h05, 13'h0064);
        chk("ev", latchedIrqEvents_r, 32'h0000_0000);
        cst(7'h05, 13'h0065);
        chk("ev", latchedIrqEvents_r, 32'h0080_0000);
        // Seconds alone differing must also flag
        wr(8'h84, 32'h0080_0000);
        cst(7'h06, 13'h0064);
        chk("ev", latchedIrqEvents_r, 32'h0080_0000);
        wr(8'h84, 32'hFFFF_FFFF);
        @(posedge clk);
        ctxHalt <= 4'h2;
        cyc(3);
        ctxEvent <= 4'h6;
        cyc(3);
        #1 chk("ev", latchedIrqEvents_r, 32'h0100_0004);
        wr(8'h84, 32'hFFFF_FFFF);
        @(posedge clk);
        ctxEvent <= 4'h0;
        ctxHalt <= 4'h0;
        cyc(2);
        ctxEvent <= 4'h2;
        cyc(3);
        #1 chk("ev", latchedIrqEvents_r, 32'h0000_0002);
        wr(8'h84, 32'hFFFF_FFFF);
        @(posedge clk);
        timingRootSet <= 1'h1;
        @(posedge clk);
        timingRootSet <= 1'h0;
        cycleStartSent <= 1'h1;
        @(posedge clk);
        cycleStartSent <= 1'h0;
        cyc(1200);
        subactionGapEnd <= 1'h1;
        @(posedge clk);
        subactionGapEnd <= 1'h0;
        cyc(200);
        #1 chk("root", {31'h0, timingRootSelect_r}, 32'h0000_0001);
        @(posedge clk);
        cycleStartSent <= 1'h1;
        @(posedge clk);
        cycleStartSent <= 1'h0;
        cyc(1240);
        #1 chk("root", {31'h0, timingRootSelect_r}, 32'h0000_0001);
        cyc(15);
        #1 chk("root", {31'h0, timingRootSelect_r}, 32'h0000_0000);
        chk("ev", latchedIrqEvents_r, 32'h0200_0000);
        complete_run;
    end

    initial begin
        cyc(20000);
        error_cnt = error_cnt + 1;
        complete_run;
    end
endmodule
